// [design/bmsp_port.v]
// serial slave port of the battery monitor: byte engine, framing, handshake
//
// Summary of operation
// RL1: every transfer is whole bytes, most significant bit first.
// RL2: slave only; host serial clock at most 2 Mbps.
// RL3: host should run the port at least twice the chain link rate.
// RL4: data out is high impedance unless chip select is low.
// RL5: full duplex when stand-alone, half duplex with handshake when chained.
// RL6: stand-alone host sends 8-bit blocks, chip select high between blocks.
// RL7: first bit sets command length; host must form commands correctly.
// RL8: chip select high over 100 us resets counters and state machine.
// RL9: pending response goes out in first two bytes of the next command.
// RL10: chained, ready goes low with a full byte; input ignored meanwhile.
// RL11: host reads eight bits; chip select rise releases ready and output.
// RL12: chained host drains all pending bytes before new commands.
// RL13: ready never asserts while chip select is already low.
// RL14: reads, actions, scans two bytes; writes three; responses two bytes.
// RL15: write is rw bit, 3-bit page, 6-bit location, 14-bit data.
// RL16: read is rw bit, page, location, six fill bits; 16 bits returned.
// RL17: read word buffered, loaded to shifter on select fall, shifted out.
// RL18: pages 1-2 volatile, 3 command, 4 nonvolatile, 5 factory test.
// RL19: all but writes are reads; writes give no reply; unknown writes ignored.
// RL20: an unrecognized read returns all zeros.
// RL21: a cut-short command counts as unrecognized; timeout resets the port.
// RL22: no CRC; page 3 location 8 is measure, tail bits name the element.
// RL23: input sampled on rising serial clock, output changes on falling.
`include "bmsp_map.vh"

module bmsp_port #(
  parameter [15:0] TIMEOUT_CYCLES = `BMSP_TIMEOUT_US * `BMSP_CLK_MHZ
) (
  input  wire        clk_sys_i,
  input  wire        reset_n_i,
  input  wire        chain_mode_i,
  input  wire        sclk_i,
  input  wire        cs_n_i,
  input  wire        din_i,
  output wire        dout_o,
  output wire        dout_oe_o,
  output wire        data_ready_n_o,
  output reg         cmd_wr_o,
  output reg         cmd_rd_o,
  output reg         cmd_measure_o,
  output reg  [2:0]  cmd_page_o,
  output reg  [5:0]  cmd_loc_o,
  output reg  [13:0] cmd_data_o,
  output reg  [5:0]  cmd_tail_o,
  output reg         page_volatile_o,
  output reg         page_command_o,
  output reg         page_nvm_o,
  output reg         page_test_o,
  input  wire        rd_valid_i,
  input  wire        rd_hit_i,
  input  wire [13:0] rd_data_i,
  output reg  [7:0]  tx_byte_o,
  output reg         tx_valid_o,
  input  wire [7:0]  rsp_byte_i,
  input  wire        rsp_valid_i,
  output wire        rsp_ready_o
);

  // ==========================================================
  // state codes
  localparam [2:0] ST_IDLE    = 3'h1;
  localparam [2:0] ST_COLLECT = 3'h2;
  localparam [2:0] ST_XMIT    = 3'h4;

  // ==========================================================
  // pin synchronisation and edges
  // oversampling at 50 MHz leaves 25 cycles per bit at the 2 Mbps ceiling
  wire [2:0] pins_s;
  wire       s_sclk = pins_s[2];
  wire       s_cs_n = pins_s[1];
  wire       s_din  = pins_s[0];
  reg        sclk_q;
  reg        cs_q;

  bmsp_sync #(
    .WIDTH     (3),
    .RESET_VAL (`BMSP_PIN_RESET)
  ) u_sync (
    .clk_sys_i (clk_sys_i),
    .reset_n_i (reset_n_i),
    .async_i   ({sclk_i, cs_n_i, din_i}),
    .sync_o    (pins_s)
  ); // see RL2

  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sclk_q <= 1'b0;
      cs_q   <= 1'b1;
    end else begin
      sclk_q <= s_sclk;
      cs_q   <= s_cs_n;
    end
  end

  wire sclk_rise = s_sclk & ~sclk_q & ~cs_q;
  wire sclk_fall = ~s_sclk & sclk_q & ~cs_q;
  wire cs_fall   = ~s_cs_n & cs_q;
  wire cs_rise   = s_cs_n & ~cs_q;

  // ==========================================================
  // registers
  reg [2:0]  state;
  reg [7:0]  shift_in;
  reg [7:0]  shift_out;
  reg [3:0]  bit_cnt;
  reg [1:0]  byte_idx;
  reg [7:0]  cmd_b0;
  reg [7:0]  cmd_b1;
  reg [15:0] out_buf;
  reg        resp_pending;
  reg        rd_wait;
  reg        drdy_low;
  reg        drdy_gap;
  reg [15:0] to_cnt;
  reg [7:0]  load_byte;

  // ==========================================================
  // response buffer
  wire       fifo_valid;
  wire [7:0] fifo_data;
  wire       fifo_pop = cs_fall & drdy_low & chain_mode_i;

  bmsp_fifo #(
    .WIDTH (`BMSP_FIFO_WIDTH),
    .DEPTH (`BMSP_FIFO_DEPTH),
    .AW    (`BMSP_FIFO_AW)
  ) u_fifo (
    .clk_sys_i   (clk_sys_i),
    .reset_n_i   (reset_n_i),
    .in_valid_i  (rsp_valid_i),
    .in_ready_o  (rsp_ready_o),
    .in_data_i   (rsp_byte_i),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_data)
  );

  // ==========================================================
  // chip select idle timeout
  wire timeout_now = s_cs_n & cs_q & (to_cnt == TIMEOUT_CYCLES - 16'h0001);

  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      to_cnt <= 16'h0000;
    end else if (~s_cs_n) begin
      to_cnt <= 16'h0000;
    end else if (to_cnt != TIMEOUT_CYCLES) begin
      to_cnt <= to_cnt + 16'h0001; // see RL8
    end
  end

  // ==========================================================
  // byte engine
  wire       byte_done = sclk_rise & (bit_cnt == `BMSP_LAST_BIT);
  wire [7:0] rx_byte   = {shift_in[6:0], s_din};
  wire       cut_short = cs_rise & (bit_cnt != `BMSP_BIT_ZERO);

  assign dout_o    = shift_out[7];
  assign dout_oe_o = ~cs_q; // see RL4

  always @* begin
    load_byte = `BMSP_BYTE_ZERO;
    if (chain_mode_i) begin
      if (drdy_low) begin
        load_byte = fifo_data; // see RL5
      end
    end else if (resp_pending) begin
      // third byte of a write carries zeros for the host to discard
      if (byte_idx == `BMSP_IDX_FIRST) begin
        load_byte = out_buf[15:8]; // see RL9
      end else if (byte_idx == `BMSP_IDX_SECOND) begin
        load_byte = out_buf[7:0]; // see RL9
      end
    end
  end

  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      shift_in  <= `BMSP_BYTE_ZERO;
      shift_out <= `BMSP_BYTE_ZERO;
      bit_cnt   <= `BMSP_BIT_ZERO;
    end else if (cs_fall) begin
      shift_out <= load_byte; // see RL17
      bit_cnt   <= `BMSP_BIT_ZERO;
    end else if (sclk_rise) begin
      shift_in <= rx_byte; // see RL23
      if (bit_cnt == `BMSP_LAST_BIT) begin
        bit_cnt <= `BMSP_BIT_ZERO; // see RL1
      end else begin
        bit_cnt <= bit_cnt + 4'h1;
      end
    end else if (sclk_fall) begin
      shift_out <= {shift_out[6:0], 1'b0}; // see RL1
    end else if (timeout_now) begin
      bit_cnt <= `BMSP_BIT_ZERO; // see RL8
    end
  end

  // ==========================================================
  // serial state machine
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= ST_IDLE;
    end else if (timeout_now) begin
      state <= ST_IDLE; // see RL8
    end else begin
      case (state)
        ST_IDLE: begin
          if (cs_fall) begin
            state <= (chain_mode_i & drdy_low) ? ST_XMIT : ST_COLLECT; // see RL10
          end
        end
        ST_COLLECT: begin
          if (cs_rise & (chain_mode_i | byte_idx == `BMSP_IDX_FIRST)) begin
            state <= ST_IDLE;
          end else if (cs_fall & chain_mode_i & drdy_low) begin
            state <= ST_XMIT;
          end
        end
        ST_XMIT: begin
          if (cs_rise) begin
            state <= ST_IDLE; // see RL11
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // half duplex handshake
  assign data_ready_n_o = ~drdy_low;

  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      drdy_low   <= 1'b0;
      drdy_gap   <= 1'b0;
      tx_byte_o  <= `BMSP_BYTE_ZERO;
      tx_valid_o <= 1'b0;
    end else begin
      tx_valid_o <= 1'b0;
      drdy_gap   <= 1'b0;
      if (~chain_mode_i) begin
        drdy_low <= 1'b0;
      end else if (cs_rise & (state == ST_XMIT)) begin
        drdy_low <= 1'b0; // see RL11
        drdy_gap <= 1'b1;
      end else if (~drdy_low & ~drdy_gap & fifo_valid & s_cs_n & cs_q) begin
        drdy_low <= 1'b1; // see RL13
      end
      // while a response byte waits, incoming bytes are not commands
      if (chain_mode_i & byte_done & (state == ST_COLLECT) & ~drdy_low) begin
        tx_byte_o  <= rx_byte; // see RL10
        tx_valid_o <= 1'b1;
      end
    end
  end

  // ==========================================================
  // stand-alone command framing and decode
  wire [2:0] rd_page  = cmd_b0[`BMSP_PAGE_HI:`BMSP_PAGE_LO];
  wire [5:0] rd_loc   = {cmd_b0[3:0], rx_byte[7:6]};
  wire [5:0] wr_loc   = {cmd_b0[3:0], cmd_b1[7:6]};
  wire       page_ok  = (rd_page >= `BMSP_PAGE_VOL1) & (rd_page <= `BMSP_PAGE_TEST);
  wire       is_write = cmd_b0[`BMSP_RW_BIT];
  wire       sa_done  = ~chain_mode_i & byte_done;
  wire       abort    = ~chain_mode_i & (cut_short | (timeout_now & byte_idx != `BMSP_IDX_FIRST));

  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      byte_idx        <= `BMSP_IDX_FIRST;
      cmd_b0          <= `BMSP_BYTE_ZERO;
      cmd_b1          <= `BMSP_BYTE_ZERO;
      out_buf         <= `BMSP_WORD_ZERO;
      resp_pending    <= 1'b0;
      rd_wait         <= 1'b0;
      cmd_wr_o        <= 1'b0;
      cmd_rd_o        <= 1'b0;
      cmd_measure_o   <= 1'b0;
      cmd_page_o      <= 3'h0;
      cmd_loc_o       <= 6'h00;
      cmd_data_o      <= 14'h0000;
      cmd_tail_o      <= 6'h00;
      page_volatile_o <= 1'b0;
      page_command_o  <= 1'b0;
      page_nvm_o      <= 1'b0;
      page_test_o     <= 1'b0;
    end else begin
      cmd_wr_o <= 1'b0;
      cmd_rd_o <= 1'b0;
      if (rd_wait & rd_valid_i) begin
        out_buf      <= rd_hit_i ? {`BMSP_DATA_PAD, rd_data_i} : `BMSP_WORD_ZERO; // see RL20
        resp_pending <= 1'b1; // see RL17
        rd_wait      <= 1'b0;
      end
      if (abort) begin
        byte_idx <= `BMSP_IDX_FIRST; // see RL21
        if ((byte_idx != `BMSP_IDX_FIRST) & ~is_write) begin
          out_buf      <= `BMSP_WORD_ZERO; // see RL21
          resp_pending <= 1'b1;
        end
      end else if (sa_done) begin
        case (byte_idx)
          `BMSP_IDX_FIRST: begin
            cmd_b0   <= rx_byte; // see RL7
            byte_idx <= `BMSP_IDX_SECOND;
          end
          `BMSP_IDX_SECOND: begin
            cmd_b1 <= rx_byte;
            if (resp_pending & ~(rd_wait & rd_valid_i)) begin
              resp_pending <= 1'b0; // see RL9
            end
            if (is_write) begin
              byte_idx <= `BMSP_IDX_THIRD; // see RL14
            end else begin
              // leading zero: read, scan or action, all answered as reads
              byte_idx        <= `BMSP_IDX_FIRST; // see RL14
              cmd_page_o      <= rd_page; // see RL16
              cmd_loc_o       <= rd_loc;
              cmd_tail_o      <= rx_byte[5:0];
              cmd_measure_o   <= (rd_page == `BMSP_PAGE_CMD) & (rd_loc == `BMSP_LOC_MEASURE); // see RL22
              page_volatile_o <= (rd_page == `BMSP_PAGE_VOL1) | (rd_page == `BMSP_PAGE_VOL2); // see RL18
              page_command_o  <= (rd_page == `BMSP_PAGE_CMD);
              page_nvm_o      <= (rd_page == `BMSP_PAGE_NVM);
              page_test_o     <= (rd_page == `BMSP_PAGE_TEST);
              if (page_ok) begin
                cmd_rd_o <= 1'b1; // see RL19
                rd_wait  <= 1'b1;
              end else begin
                out_buf      <= `BMSP_WORD_ZERO; // see RL20
                resp_pending <= 1'b1;
              end
            end
          end
          `BMSP_IDX_THIRD: begin
            byte_idx        <= `BMSP_IDX_FIRST;
            cmd_page_o      <= rd_page; // see RL15
            cmd_loc_o       <= wr_loc;
            cmd_data_o      <= {cmd_b1[5:0], rx_byte};
            cmd_tail_o      <= 6'h00;
            cmd_measure_o   <= 1'b0;
            page_volatile_o <= (rd_page == `BMSP_PAGE_VOL1) | (rd_page == `BMSP_PAGE_VOL2); // see RL18
            page_command_o  <= (rd_page == `BMSP_PAGE_CMD);
            page_nvm_o      <= (rd_page == `BMSP_PAGE_NVM);
            page_test_o     <= (rd_page == `BMSP_PAGE_TEST);
            // writes leave no reply; a write to an unknown page does nothing
            cmd_wr_o        <= page_ok; // see RL19
          end
          default: begin
            byte_idx <= `BMSP_IDX_FIRST;
          end
        endcase
      end
      if (chain_mode_i) begin
        byte_idx <= `BMSP_IDX_FIRST;
      end
    end
  end

endmodule // bmsp_port

// [design/bmsp_map.vh]
// constants shared by the battery-monitor host serial port design files
`ifndef BMSP_MAP_VH
`define BMSP_MAP_VH

// ==========================================================
// timing
`define BMSP_CLK_MHZ        16'h0032
`define BMSP_TIMEOUT_US     16'h0064
`define BMSP_MAX_SCLK_KBPS  2000

// ==========================================================
// byte framing
`define BMSP_LAST_BIT       4'h7
`define BMSP_BIT_ZERO       4'h0
`define BMSP_IDX_FIRST      2'h0
`define BMSP_IDX_SECOND     2'h1
`define BMSP_IDX_THIRD      2'h2
`define BMSP_RW_BIT         7
`define BMSP_PAGE_HI        6
`define BMSP_PAGE_LO        4

// ==========================================================
// page and location codes
`define BMSP_PAGE_VOL1      3'h1
`define BMSP_PAGE_VOL2      3'h2
`define BMSP_PAGE_CMD       3'h3
`define BMSP_PAGE_NVM       3'h4
`define BMSP_PAGE_TEST      3'h5
`define BMSP_LOC_MEASURE    6'h08
`define BMSP_WORD_ZERO      16'h0000
`define BMSP_BYTE_ZERO      8'h00
`define BMSP_DATA_PAD       2'h0

// ==========================================================
// pin synchroniser and response buffer
`define BMSP_PIN_RESET      3'h2
`define BMSP_FIFO_WIDTH     8
`define BMSP_FIFO_DEPTH     16
`define BMSP_FIFO_AW        4

`endif

// [design/bmsp_sync.v]
// three-stage pin synchroniser with agreement filter
`include "bmsp_map.vh"

module bmsp_sync #(
  parameter             WIDTH     = 3,
  parameter [WIDTH-1:0] RESET_VAL = `BMSP_PIN_RESET
) (
  input  wire             clk_sys_i,
  input  wire             reset_n_i,
  input  wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);

  // ==========================================================
  // per-bit stages
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      reg meta;
      reg stage2;
      reg stage3;
      reg level;
      always @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          meta   <= RESET_VAL[g];
          stage2 <= RESET_VAL[g];
          stage3 <= RESET_VAL[g];
          level  <= RESET_VAL[g];
        end else begin
          meta   <= async_i[g];
          stage2 <= meta;
          stage3 <= stage2;
          // a change counts only once the two settled stages agree
          if (stage2 == stage3) begin
            level <= stage3;
          end
        end
      end
      assign sync_o[g] = level;
    end
  endgenerate

endmodule // bmsp_sync

// [design/bmsp_fifo.v]
// response byte buffer between the chain side and the serial port
`include "bmsp_map.vh"

module bmsp_fifo #(
  parameter WIDTH = `BMSP_FIFO_WIDTH,
  parameter DEPTH = `BMSP_FIFO_DEPTH,
  parameter AW    = `BMSP_FIFO_AW
) (
  input  wire             clk_sys_i,
  input  wire             reset_n_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);

  // ==========================================================
  // storage and pointers
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;

  wire push = in_valid_i & in_ready_o;
  wire pop  = out_valid_o & out_ready_i;

  assign in_ready_o  = (count != DEPTH[AW:0]);
  assign out_valid_o = (count != {(AW+1){1'b0}});
  assign out_data_o  = mem[rd_ptr];

  always @(posedge clk_sys_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push & ~pop) begin
        count <= count + {{AW{1'b0}}, 1'b1};
      end else if (pop & ~push) begin
        count <= count - {{AW{1'b0}}, 1'b1};
      end
    end
  end

endmodule // bmsp_fifo

// [bench/bmsp_port_asserts.sv]
// assertion checker for the battery-monitor host serial port
module bmsp_port_asserts #(
  parameter [15:0] TIMEOUT_CYCLES = 16'h1388
) (
  input wire       clk_sys_i,
  input wire       reset_n_i,
  input wire       chain_mode_i,
  input wire       cs_n_i,
  input wire       dout_oe_o,
  input wire       data_ready_n_o,
  input wire       cmd_wr_o,
  input wire       cmd_rd_o,
  input wire       cmd_measure_o,
  input wire [2:0] cmd_page_o,
  input wire [5:0] cmd_loc_o,
  input wire       page_volatile_o,
  input wire       page_command_o,
  input wire       page_nvm_o,
  input wire       page_test_o,
  input wire       tx_valid_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!reset_n_i);
  // =========================================
  // sequences: eight samples outlast the pin filter lag
  sequence s_cs_idle;
    cs_n_i [*8];
  endsequence
  sequence s_cs_busy;
    !cs_n_i [*8];
  endsequence
  sequence s_rdy_release;
    ##[0:3] data_ready_n_o;
  endsequence
  // =========================================
  // properties
  property p_oe_off;
    s_cs_idle |-> !dout_oe_o;
  endproperty
  property p_oe_on;
    s_cs_busy |-> dout_oe_o;
  endproperty
  property p_rdy_cs;
    $fell(data_ready_n_o) |-> !dout_oe_o;
  endproperty
  property p_ignore_din;
    chain_mode_i && !data_ready_n_o |-> !tx_valid_o;
  endproperty
  property p_release;
    chain_mode_i && $fell(dout_oe_o) |-> s_rdy_release;
  endproperty
  property p_sa_only;
    (cmd_wr_o || cmd_rd_o) |-> !chain_mode_i && !tx_valid_o;
  endproperty
  property p_tx_chain;
    tx_valid_o |-> chain_mode_i;
  endproperty
  property p_pulse;
    (cmd_wr_o || cmd_rd_o) |-> !(cmd_wr_o && cmd_rd_o) ##1 !(cmd_wr_o || cmd_rd_o);
  endproperty
  property p_page_ok;
    (cmd_wr_o || cmd_rd_o) |-> cmd_page_o inside {[3'h1:3'h5]};
  endproperty
  property p_page_map;
    $stable(cmd_page_o) [*3] |-> page_volatile_o == (cmd_page_o inside {3'h1, 3'h2})
      && page_command_o == (cmd_page_o == 3'h3) && page_nvm_o == (cmd_page_o == 3'h4)
      && page_test_o == (cmd_page_o == 3'h5);
  endproperty
  property p_rdy_sa;
    !chain_mode_i [*2] |-> data_ready_n_o;
  endproperty
  property p_measure;
    cmd_rd_o |-> cmd_measure_o == (cmd_page_o == 3'h3 && cmd_loc_o == 6'h08);
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("output driven while deselected");
  a_oe_on: assert property (p_oe_on) else $error("output not driven while selected");
  a_rdy_cs: assert property (p_rdy_cs) else $error("ready raised while selected");
  a_ignore_din: assert property (p_ignore_din) else $error("byte taken while ready low");
  a_release: assert property (p_release) else $error("ready not released");
  a_sa_only: assert property (p_sa_only) else $error("command decoded in chain mode");
  a_tx_chain: assert property (p_tx_chain) else $error("chain byte in stand-alone mode");
  a_pulse: assert property (p_pulse) else $error("command strobe malformed");
  a_page_ok: assert property (p_page_ok) else $error("command on unknown page");
  a_page_map: assert property (p_page_map) else $error("page decode wrong");
  a_measure: assert property (p_measure) else $error("measure flag wrong");
  a_rdy_sa: assert property (p_rdy_sa) else $error("ready low in stand-alone mode");
endmodule // bmsp_port_asserts

bind bmsp_port bmsp_port_asserts #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) bmsp_port_asserts_inst (.*);

// [bench/bmsp_host_model.sv]
// host serial bus master model driving the port's pins
module bmsp_host_model #(
  parameter integer HALF = 13
) (
  input  wire  clk_sys_i,
  input  wire  dout_i,
  input  wire  dout_oe_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic din_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last_q = 1'b0;
  // no pull on the line: a released output shows the inverse of its last bit
  wire  line_w = dout_oe_i ? dout_i : ~last_q;
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o  = 1'b0;
  end
  always @(posedge clk_sys_i) begin
    if (dout_oe_i) begin
      last_q <= dout_i;
    end
  end
  task automatic idle(input integer n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  // =========================================
  // one byte in its own select window, mode 0; call just after an edge
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, input integer nb = 8);
    integer i;
    cs_n_o <= 1'b0;
    for (i = 7; i >= 8 - nb; i--) begin
      din_o <= tx[i];
      idle(HALF);
      sclk_o <= 1'b1;
      rx[i] = line_w;
      idle(HALF);
      sclk_o <= 1'b0;
    end
    din_o  <= ~tx[0];
    cs_n_o <= 1'b1;
    idle(HALF);
  endtask
endmodule // bmsp_host_model

// [bench/battery_monitor_host_serial_port_bench.sv]
// self-checking bench for the battery-monitor host serial port
module battery_monitor_host_serial_port_bench;
  timeunit 1ns;
  timeprecision 1ns;
  // shortened idle timeout keeps the run brief
  localparam [15:0] TMO = 16'h00C8;
  logic        clk_sys_i = 1'b0;
  logic        reset_n_i, chain_mode_i, rd_valid_i, rd_hit_i, rsp_valid_i;
  logic [13:0] rd_data_i;
  logic [7:0]  rsp_byte_i;
  wire         sclk_i, cs_n_i, din_i, dout_o, dout_oe_o, data_ready_n_o, cmd_wr_o, cmd_rd_o;
  wire         cmd_measure_o, page_volatile_o, page_command_o, page_nvm_o, page_test_o;
  wire         tx_valid_o, rsp_ready_o;
  wire [2:0]   cmd_page_o;
  wire [5:0]   cmd_loc_o, cmd_tail_o;
  wire [13:0]  cmd_data_o;
  wire [7:0]   tx_byte_o;
  integer      num_errors = 0, checks_done = 0, seed = 61136;
  logic [15:0] n_cmd = 16'h0000, n_tx = 16'h0000, pend = 16'h0000;
  logic [10:0] g_fld;
  logic [5:0]  g_tail;
  logic [13:0] g_data;
  logic [7:0]  g_tx;
  logic        plan_hit;
  logic [13:0] plan_data;
  logic [7:0]  q[$];

  bmsp_port #(.TIMEOUT_CYCLES(TMO)) bmsp_port_inst (.*);
  bmsp_host_model bmsp_host_model_inst (.clk_sys_i(clk_sys_i), .dout_i(dout_o), .dout_oe_i(dout_oe_o),
    .sclk_o(sclk_i), .cs_n_o(cs_n_i), .din_o(din_i));

  always #10 clk_sys_i = ~clk_sys_i;

  // =========================================
  // read responder and output monitor
  always @(posedge clk_sys_i) begin
    rd_valid_i <= 1'b0;
    if (cmd_rd_o || cmd_wr_o) begin
      n_cmd  <= n_cmd + 16'h0001;
      g_fld  <= {cmd_wr_o, cmd_measure_o & cmd_rd_o, cmd_page_o, cmd_loc_o};
      g_tail <= cmd_tail_o;
      g_data <= cmd_data_o;
    end
    if (cmd_rd_o) begin
      rd_valid_i <= 1'b1;
      rd_hit_i   <= plan_hit;
      rd_data_i  <= plan_data;
    end
    if (tx_valid_o) begin
      n_tx <= n_tx + 16'h0001;
      g_tx <= tx_byte_o;
    end
  end

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [15:0] exp_word(input logic ok, input logic hit, input logic [13:0] d);
    exp_word = (ok && hit) ? {2'h0, d} : 16'h0000;
  endfunction

  task automatic final_report;
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // =========================================
  // one stand-alone command; non-measure reads carry a zero tail
  task automatic run_cmd(input logic wr, input logic [2:0] pg, input logic [5:0] loc, input logic [13:0] dw);
    logic [7:0]  r1, r2, r3;
    logic [15:0] c0;
    logic        ok, meas;
    c0 = n_cmd;
    ok = pg >= 3'h1 && pg <= 3'h5;
    meas = !wr && pg == 3'h3 && loc == 6'h08;
    if (!wr && !meas) dw[13:8] = 6'h00;
    plan_hit = 1'($random(seed));
    plan_data = 14'($random(seed));
    bmsp_host_model_inst.xfer({wr, pg, loc[5:2]}, r1);
    bmsp_host_model_inst.xfer({loc[1:0], dw[13:8]}, r2);
    if (wr) bmsp_host_model_inst.xfer(dw[7:0], r3);
    chk("response", pend, {r1, r2});
    repeat (4) @(posedge clk_sys_i);
    chk("commands", c0 + ok, n_cmd);
    if (ok) begin
      chk("fields", {wr, meas, pg, loc}, g_fld);
      chk("payload", wr ? dw : dw[13:8], wr ? g_data : g_tail);
    end
    pend = wr ? 16'h0000 : exp_word(ok, plan_hit, plan_data);
  endtask

  initial begin
    repeat (60000) @(posedge clk_sys_i);
    num_errors++;
    final_report();
  end

  initial begin
    logic       wr;
    logic [5:0] loc;
    logic [7:0] r;
    integer     k, w;
    reset_n_i = 1'b0;
    chain_mode_i = 1'b0;
    rsp_valid_i = 1'b0;
    rsp_byte_i = 8'h00;
    repeat (2) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    @(posedge clk_sys_i);
    // every page twice; k 3 measure, k 8 read page 0, k 15 write page 7
    for (k = 0; k < 16; k++) begin
      wr = (k == 3 || k == 8) ? 1'b0 : (k == 15) ? 1'b1 : 1'($random(seed));
      loc = (k == 3) ? 6'h08 : 6'($random(seed));
      run_cmd(wr, 3'(k), loc, 14'($random(seed)));
    end
    // half a read, then select idles past the timeout
    w = n_cmd;
    bmsp_host_model_inst.xfer(8'h12, r);
    repeat (TMO + 20) @(posedge clk_sys_i);
    chk("aborted", w, n_cmd);
    // a second byte cut after four bits aborts the read as well
    bmsp_host_model_inst.xfer(8'h12, r);
    bmsp_host_model_inst.xfer(8'h80, r, 4);
    chk("cut short", w, n_cmd);
    pend = 16'h0000;
    run_cmd(1'b0, 3'h2, 6'h2A, 14'h0000);
    // chained mode entered under a second reset
    reset_n_i <= 1'b0;
    chain_mode_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    @(posedge clk_sys_i);
    bmsp_host_model_inst.xfer(8'hC3, r);
    repeat (4) @(posedge clk_sys_i);
    chk("chain byte", {16'h0001, 8'hC3}, {n_tx, g_tx});
    // fill the buffer until refused while the host stalls
    rsp_valid_i <= 1'b1;
    rsp_byte_i <= 8'($random(seed));
    for (k = 0; k < 40; k++) begin
      @(posedge clk_sys_i);
      if (rsp_ready_o !== 1'b1) break;
      q.push_back(rsp_byte_i);
      rsp_byte_i <= 8'($random(seed));
    end
    rsp_valid_i <= 1'b0;
    chk("buffer depth", 16, q.size());
    // drain every byte before any new command; select only after ready
    while (q.size() > 0) begin
      for (w = 0; w < 100 && data_ready_n_o !== 1'b0; w++) @(posedge clk_sys_i);
      bmsp_host_model_inst.xfer(8'($random(seed)), r);
      chk("response byte", q.pop_front(), r);
    end
    repeat (20) @(posedge clk_sys_i);
    chk("ready idle", 1'b1, data_ready_n_o);
    chk("input ignored", 16'h0001, n_tx);
    final_report();
  end
endmodule // battery_monitor_host_serial_port_bench
